// ===== rhpm_top.sv
// What this block does
// - register sits at offset 4ch from the memory base at config 10h
// - register reset value is a parameter
// - per-port mode: masked port follows only single-port power commands
// - unmasked port follows only all-ports power commands
// - ganged mode ignores the mask entirely
// - mask bit 0 reserved, bit n is port n
// - fixed-flag zero means attached device removable
// - fixed-flag one means attached device permanently attached
// - fixed-flag bit 0 reserved, bit n is port n
// - mode zero powers all ports together, one powers per port
// - mode matters only when always-powered flag is clear
// - per-port mode: global on affects only unmasked ports
// - per-port mode: global off affects only unmasked ports
//
// file holds the register, the mode decode and one rhpm_port_power instance per port
// assumes a simple word access port decoded inside the memory window
`timescale 1ns/1ps
module rhpm_top #(
    parameter logic [31:0] RESET_VAL = rhpm_pkg::RHPM_RESET_VAL
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // register access within the memory window
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // power configuration held by the neighbouring descriptor register
    input  wire logic        always_powered_flag,
    input  wire logic        switching_granularity_sel,
    // power commands, one-cycle pulses
    input  wire logic        all_ports_power_on_cmd,
    input  wire logic        all_ports_power_off_cmd,
    input  wire logic [15:0] single_port_on_cmd,
    input  wire logic [15:0] single_port_off_cmd,
    // outputs
    output logic      [15:0] port_power_select_mask,
    output logic      [15:0] attached_fixed_flags,
    output logic      [15:0] port_powered_state
);
    // ****************************************
    // helpers
    // ****************************************
    // values after reset, with the same bits dropped as on a write
    localparam logic [15:0] RST_MASK  =
        RESET_VAL[rhpm_pkg::RHPM_MASK_LSB +: rhpm_pkg::RHPM_FIELD_W]
        & rhpm_pkg::RHPM_VALID_BITS;
    localparam logic [15:0] RST_FIXED =
        RESET_VAL[rhpm_pkg::RHPM_FIXED_LSB +: rhpm_pkg::RHPM_FIELD_W]
        & rhpm_pkg::RHPM_VALID_BITS;

    // keeps port bits 1..n only; bit 0 has no port behind it
    function automatic logic [15:0] keep_ports(input logic [15:0] raw);
        keep_ports = raw & rhpm_pkg::RHPM_VALID_BITS;
    endfunction

    // ****************************************
    // register decode
    // ****************************************
    // a single register in the bank: a full compare on the offset is
    // cheap and leaves every other offset of the window to other blocks
    wire logic        hit_w;
    wire logic        wr_w;
    wire logic        rd_w;
    wire logic [15:0] valid_w;
    wire logic [15:0] wr_mask_w;
    wire logic [15:0] wr_fixed_w;
    logic      [15:0] mask_q;
    logic      [15:0] mask_d;
    logic      [15:0] fixed_q;
    logic      [15:0] fixed_d;
    logic      [31:0] rdata_d;

    assign hit_w      = (reg_addr == rhpm_pkg::RHPM_MASK_REMOV_OFS);
    assign wr_w       = reg_wr && hit_w;
    assign rd_w       = reg_rd && hit_w;
    assign valid_w    = rhpm_pkg::RHPM_VALID_BITS;
    // field positions come from the package so both halves stay in step
    assign wr_mask_w  = reg_wdata[rhpm_pkg::RHPM_MASK_LSB +:
                                  rhpm_pkg::RHPM_FIELD_W];
    assign wr_fixed_w = reg_wdata[rhpm_pkg::RHPM_FIXED_LSB +:
                                  rhpm_pkg::RHPM_FIELD_W];
    // reserved bits dropped on write so they can never read back
    assign mask_d  = wr_w ? keep_ports(wr_mask_w) : mask_q;
    assign fixed_d = wr_w ? keep_ports(wr_fixed_w) : fixed_q;
    // unmapped offsets and idle cycles read zero
    assign rdata_d = rd_w ? {mask_q, fixed_q} : 32'h0000_0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q  <= RST_MASK;
            fixed_q <= RST_FIXED;
        end else begin
            mask_q  <= mask_d;
            fixed_q <= fixed_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata              <= 32'h0000_0000;
            port_power_select_mask <= 16'h0000;
            attached_fixed_flags   <= 16'h0000;
        end else begin
            reg_rdata              <= rdata_d;
            port_power_select_mask <= mask_d;
            attached_fixed_flags   <= fixed_d;
        end
    end

    // ****************************************
    // port power
    // ****************************************
    rhpm_pkg::rhpm_mode_t mode_w;
    assign mode_w = switching_granularity_sel ? rhpm_pkg::RHPM_PER_PORT
                                              : rhpm_pkg::RHPM_GANGED;
    wire logic per_port_w = (mode_w == rhpm_pkg::RHPM_PER_PORT);

    assign port_powered_state[0] = 1'b0;
    genvar gi;
    generate
        for (gi = 1; gi < 16; gi++) begin : g_port
            if (gi <= rhpm_pkg::RHPM_NUM_PORTS) begin : g_on
                rhpm_port_power u_pwr (
                    .clk                     (clk),
                    .arst_n                  (arst_n),
                    .always_powered_flag     (always_powered_flag),
                    .per_port_mode           (per_port_w),
                    .port_power_select_mask  (mask_q[gi]),
                    .all_ports_power_on_cmd  (all_ports_power_on_cmd),
                    .all_ports_power_off_cmd (all_ports_power_off_cmd),
                    .single_port_on_cmd      (single_port_on_cmd[gi]),
                    .single_port_off_cmd     (single_port_off_cmd[gi]),
                    .port_powered_state      (port_powered_state[gi])
                );
            end else begin : g_off
                assign port_powered_state[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        ((mask_q & ~valid_w) == 16'h0000)
        && ((fixed_q & ~valid_w) == 16'h0000))
        else $error("reserved bit set");
    a_write_stores: assert property (
        @(posedge clk) disable iff (!arst_n)
        wr_w |=> (fixed_q == keep_ports($past(wr_fixed_w)))
                 && (mask_q == keep_ports($past(wr_mask_w))))
        else $error("write not stored");
    a_mask_out: assert property (
        @(posedge clk) disable iff (!arst_n)
        wr_w |=> port_power_select_mask == keep_ports($past(wr_mask_w)))
        else $error("mask output not updated");
    a_fixed_out: assert property (
        @(posedge clk) disable iff (!arst_n)
        wr_w |=> attached_fixed_flags == keep_ports($past(wr_fixed_w)))
        else $error("fixed flags output not updated");
    a_read_back: assert property (
        @(posedge clk) disable iff (!arst_n)
        (rd_w && !reg_wr) |=> (reg_rdata == {mask_q, fixed_q}))
        else $error("read data wrong");
    a_read_idle: assert property (
        @(posedge clk) disable iff (!arst_n)
        !rd_w |=> (reg_rdata == 32'h0000_0000))
        else $error("read data not zero outside a read");
    a_hold_value: assert property (
        @(posedge clk) disable iff (!arst_n)
        !wr_w |=> $stable(mask_q) && $stable(fixed_q))
        else $error("register changed without a write");
    a_ganged_on: assert property (
        @(posedge clk) disable iff (!arst_n)
        (!per_port_w && all_ports_power_on_cmd) |=> port_powered_state[1])
        else $error("ganged on missed");
    a_ganged_off: assert property (
        @(posedge clk) disable iff (!arst_n)
        (!per_port_w && !always_powered_flag && all_ports_power_off_cmd
         && !all_ports_power_on_cmd) |=> !port_powered_state[4])
        else $error("ganged off missed");
    a_ganged_mask_ignored: assert property (
        @(posedge clk) disable iff (!arst_n)
        (!per_port_w && !always_powered_flag && mask_q[3]
         && single_port_on_cmd[3] && !all_ports_power_on_cmd
         && !port_powered_state[3]) |=> !port_powered_state[3])
        else $error("mask obeyed in ganged mode");
    a_masked_single: assert property (
        @(posedge clk) disable iff (!arst_n)
        (per_port_w && mask_q[1] && single_port_on_cmd[1])
        |=> port_powered_state[1])
        else $error("masked port missed its own on");
    a_masked_keeps: assert property (
        @(posedge clk) disable iff (!arst_n)
        (per_port_w && !always_powered_flag && mask_q[2]
         && !single_port_on_cmd[2] && !single_port_off_cmd[2])
        |=> $stable(port_powered_state[2]))
        else $error("masked port followed a global command");
    a_unmasked_off: assert property (
        @(posedge clk) disable iff (!arst_n)
        (per_port_w && !always_powered_flag && !mask_q[1]
         && all_ports_power_off_cmd && !all_ports_power_on_cmd)
        |=> !port_powered_state[1])
        else $error("global off missed");
    a_unmasked_on: assert property (
        @(posedge clk) disable iff (!arst_n)
        (per_port_w && !mask_q[2] && all_ports_power_on_cmd)
        |=> port_powered_state[2])
        else $error("global on missed");
    a_set_wins: assert property (
        @(posedge clk) disable iff (!arst_n)
        (per_port_w && !mask_q[1] && all_ports_power_on_cmd
         && all_ports_power_off_cmd) |=> port_powered_state[1])
        else $error("global on lost against global off");
    a_always_on: assert property (
        @(posedge clk) disable iff (!arst_n)
        always_powered_flag[*2] |-> port_powered_state[1])
        else $error("always powered port off");
    a_always_all: assert property (
        @(posedge clk) disable iff (!arst_n)
        always_powered_flag
        |=> port_powered_state == rhpm_pkg::RHPM_VALID_BITS)
        else $error("always powered flag left a port off");
    c_write: cover property (@(posedge clk) wr_w);
    c_masked_single: cover property (@(posedge clk)
        per_port_w && mask_q[1] && single_port_on_cmd[1]);
    c_ganged_off: cover property (@(posedge clk)
        !per_port_w && all_ports_power_off_cmd);
    c_always_powered: cover property (@(posedge clk) always_powered_flag);
    c_masked_global: cover property (@(posedge clk)
        per_port_w && mask_q[2] && all_ports_power_off_cmd);
endmodule

// ===== rhpm_pkg.sv
// package for the root hub port power mask and removable register block
// assumes a 32-bit register access port and up to 15 downstream ports
package rhpm_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] RHPM_MEM_BAR_CFG_ADDR = 32'h0000_0010;
    localparam logic [11:0] RHPM_MASK_REMOV_OFS   = 12'h04c;
    localparam int          RHPM_MASK_LSB         = 16;
    localparam int          RHPM_FIXED_LSB        = 0;
    localparam int          RHPM_FIELD_W          = 16;
    localparam int          RHPM_NUM_PORTS        = 4;
    // ports 1..n valid, bit 0 reserved
    localparam logic [15:0] RHPM_VALID_BITS       = 16'h001e;
    // reset value of the register, implementation choice
    localparam logic [31:0] RHPM_RESET_VAL        = 32'h0000_0000;
    // ****************************************
    // switching modes
    // ****************************************
    typedef enum logic {
        RHPM_GANGED,
        RHPM_PER_PORT
    } rhpm_mode_t;
endpackage

// ===== rhpm_port_power.sv
// one downstream port's power state
// assumes commands are single-cycle pulses on the register clock
`timescale 1ns/1ps
module rhpm_port_power (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // control
    input  wire logic always_powered_flag,
    input  wire logic per_port_mode,
    input  wire logic port_power_select_mask,
    // commands
    input  wire logic all_ports_power_on_cmd,
    input  wire logic all_ports_power_off_cmd,
    input  wire logic single_port_on_cmd,
    input  wire logic single_port_off_cmd,
    // state
    output logic      port_powered_state
);
    // ****************************************
    // command steering
    // ****************************************
    wire logic use_single = per_port_mode && port_power_select_mask;
    wire logic use_global = !use_single;
    wire logic set_w = use_single ? single_port_on_cmd
                                  : all_ports_power_on_cmd;
    wire logic clr_w = use_single ? single_port_off_cmd
                                  : all_ports_power_off_cmd;
    logic pwr_d;
    assign pwr_d = always_powered_flag ? 1'b1 :
                   set_w ? 1'b1 : (clr_w ? 1'b0 : port_powered_state);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_powered_state <= 1'b0;
        end else begin
            port_powered_state <= pwr_d;
        end
    end
    // use_global kept readable for checks
    a_global_ignored: assert property (
        @(posedge clk) disable iff (!arst_n)
        (use_single && !always_powered_flag && all_ports_power_on_cmd
         && !single_port_on_cmd && !port_powered_state)
        |=> !port_powered_state)
        else $error("masked port reacted to global on");
    a_single_ignored: assert property (
        @(posedge clk) disable iff (!arst_n)
        (use_global && !always_powered_flag && single_port_on_cmd
         && !all_ports_power_on_cmd && !port_powered_state)
        |=> !port_powered_state)
        else $error("unmasked port reacted to port command");
endmodule

// ===== rhpm_top_tb.sv
// self-checking bench for the port power mask and removable register block
// assumes the design package is compiled first; no partner model is needed
`timescale 1ns/1ps
module rhpm_top_tb;
    // nonzero reset value, so reserved bits must be seen dropped after reset
    localparam logic [31:0] RV = 32'h8012_c00a;
    logic        clk;
    logic        arst_n;
    logic        reg_wr;
    logic        reg_rd;
    logic        apf;
    logic        sel;
    logic        gon;
    logic        goff;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [15:0] son;
    logic [15:0] soff;
    logic [15:0] mask;
    logic [15:0] flags;
    logic [15:0] pwr;
    logic [15:0] m_q;
    logic [15:0] f_q;
    logic [15:0] p_q;
    logic [31:0] rd_q;
    logic [11:0] addrs [4] = '{12'h04c, 12'h048, 12'h050, 12'h04c};
    int          error_cnt;
    int          n_compared;

    rhpm_top #(.RESET_VAL(RV)) i_dut (
        .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .always_powered_flag(apf), .switching_granularity_sel(sel),
        .all_ports_power_on_cmd(gon), .all_ports_power_off_cmd(goff),
        .single_port_on_cmd(son), .single_port_off_cmd(soff),
        .port_power_select_mask(mask), .attached_fixed_flags(flags),
        .port_powered_state(pwr));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("errors=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset(input int n);
        // idle first, so no request is taken by the edge before reset
        {reg_wr, reg_rd, apf, sel, gon, goff} = 6'h00;
        {son, soff, reg_wdata, reg_addr} = '0;
        @(negedge clk);
        arst_n = 1'b0;
        repeat (n) @(negedge clk);
        check({16'h0, mask | flags | pwr}, 32'h0);
        check(reg_rdata, 32'h0);
        arst_n = 1'b1;
        // register holds the parameter value with reserved bits dropped
        m_q  = RV[31:16] & 16'h001e;
        f_q  = RV[15:0] & 16'h001e;
        p_q  = 16'h0;
        rd_q = 32'h0;
    endtask

    // ****************************************
    // reference model, one clock step
    // ****************************************
    task automatic model_step;
        logic mk;
        logic on;
        logic off;
        rd_q = (reg_rd && reg_addr == 12'h04c) ? {m_q, f_q} : 32'h0;
        for (int p = 1; p <= 4; p++) begin
            // steering uses the mask held before any same-cycle write
            mk  = sel && m_q[p];
            on  = mk ? son[p] : gon;
            off = mk ? soff[p] : goff;
            if (apf || on) begin
                p_q[p] = 1'b1;
            end else if (off) begin
                p_q[p] = 1'b0;
            end
        end
        if (reg_wr && reg_addr == 12'h04c) begin
            m_q = reg_wdata[31:16] & 16'h001e;
            f_q = reg_wdata[15:0] & 16'h001e;
        end
    endtask

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        // 400 steps plus two resets need well under 1000 cycles
        repeat (2000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        arst_n = 1'b0;
        {reg_wr, reg_rd, apf, sel, gon, goff} = 6'h00;
        {son, soff, reg_wdata, reg_addr} = '0;
        error_cnt  = 0;
        n_compared = 0;
        void'($urandom(32'h469ca599));
        do_reset(12);
        for (int i = 0; i < 400; i++) begin
            if (i == 200) begin
                do_reset(3);
            end
            reg_wr    = ($urandom % 3) == 0;
            reg_rd    = ($urandom % 3) == 0;
            reg_addr  = addrs[$urandom % 4];
            reg_wdata = $urandom;
            apf       = ($urandom % 16) == 0;
            sel       = 1'($urandom);
            gon       = ($urandom % 5) == 0;
            goff      = ($urandom % 5) == 0;
            son       = 16'($urandom);
            soff      = 16'($urandom);
            model_step();
            @(negedge clk);
            check({16'h0, mask}, {16'h0, m_q});
            check({16'h0, flags}, {16'h0, f_q});
            check({16'h0, pwr}, {16'h0, p_q});
            check(reg_rdata, rd_q);
        end
        tally_and_finish();
    end
endmodule
